/* File: src/isc_regs.svh */
// Constants for the segment-based two-wire bus master
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH
`define ISC_MODE_W        3
`define ISC_MODE_I2C      3'h3
`define ISC_EXP_W         4
`define ISC_LIN_W         4
`define ISC_REF_HZ        24000000
`define ISC_SYS_HZ        25000000
`define ISC_PRE_W         12
`define ISC_PRE_CNT       12'(((`ISC_SYS_HZ + `ISC_REF_HZ - 1) / `ISC_REF_HZ) - 1)
`define ISC_DIV_W         20
`define ISC_DIV_MIN       20'h0001E
`define ISC_BIT_LAST      4'h8
`define ISC_PH_LAST       2'h3
`endif

/* File: src/isc_pkg.sv */
// Types for the segment-based two-wire bus master
package isc_pkg;
    typedef enum logic [4:0] {
        ISC_IDLE  = 5'h01,
        ISC_START = 5'h02,
        ISC_BYTE  = 5'h04,
        ISC_STOP  = 5'h08,
        ISC_DONE  = 5'h10
    } isc_state_e;
endpackage : isc_pkg

/* File: src/isc_master.sv */
// Segment-based two-wire bus master with open-collector lines
// Functional notes
// - Master function active only when the mode field holds three.
// - Standard and fast speeds; programmed clock should stay at or below 400 kHz.
// - No arbitration; sole master assumed, multi-master unsupported.
// - Open-collector data and clock; system supplies external pull-ups.
// - Bit rate is reference over 2*(linear+1)*2^exponent.
// - One segment per request, chosen by one-hot start, stop, send, receive.
// - Receive segment answers ACK or NACK per the acknowledge select bit.
// - Start on idle bus; repeated start after transmit or NACK frame.
// - Send shifts bit 7 first down to bit 0, then samples acknowledge.
// - Stop segment issues stop condition; no bits set means nothing pending.
`timescale 1ns/100ps
`include "isc_regs.svh"
module isc_master
    import isc_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire logic [`ISC_MODE_W-1:0] serial_ctrl_mode_field,
    input  wire logic [`ISC_EXP_W-1:0]  rate_exponent,
    input  wire logic [`ISC_LIN_W-1:0]  rate_linear_column,
    input  wire logic                   seg_start_req,
    input  wire logic                   seg_stop_req,
    input  wire logic                   seg_send_req,
    input  wire logic                   seg_recv_req,
    input  wire logic                   recv_ack_select,
    input  wire logic [7:0]             tx_data,
    output logic      [7:0]             rx_data,
    output logic                        rx_nack,
    output logic                        seg_done,
    output logic                        busy,
    input  wire logic                   scl_in,
    output logic                        scl_out,
    output logic                        scl_oe,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe
);
    isc_state_e                state_q;
    logic [`ISC_PRE_W-1:0]     pre_q;
    logic                      ref_tick;
    logic [`ISC_DIV_W-1:0]     div_q;
    logic [`ISC_DIV_W-1:0]     div_end;
    logic [`ISC_DIV_W-1:0]     div_prod;
    logic [`ISC_DIV_W-1:0]     div_lim;
    logic                      ph_tick;
    logic [1:0]                ph_q;
    logic [3:0]                bit_q;
    logic [8:0]                sh_q;
    logic                      recv_q;
    logic                      scl_low_q;
    logic                      sda_low_q;
    logic [1:0]                sda_sync_q;
    logic [1:0]                scl_sync_q;
    logic                      enabled;
    logic                      one_hot;

    assign enabled = (serial_ctrl_mode_field == `ISC_MODE_I2C);
    // Exactly one request bit; illegal combinations are ignored
    assign one_hot = ($countones({seg_start_req, seg_stop_req, seg_send_req,
                                  seg_recv_req}) == 1);

    // Reference tick divides the system clock by two, giving 12.5 MHz in place of the 24 MHz source
    always_ff @(posedge clk_sys) begin
        if (!nrst || pre_q == `ISC_PRE_CNT) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 12'h001;
        end
    end
    assign ref_tick = (pre_q == `ISC_PRE_CNT);

    // Quarter-bit phase: one bit is four phases, so 4 phases = 2*(lin+1)*2^exp refs
    // Limitation: resolution is halved relative to the nominal formula
    assign div_prod = `ISC_DIV_W'({16'h0000, rate_linear_column} + 20'h00001)
                      << rate_exponent;
    // Products under the floor of 30 are raised to it, capping the bit rate near 208 kHz with the 12.5 MHz tick
    assign div_lim  = (div_prod < `ISC_DIV_MIN) ? `ISC_DIV_MIN : div_prod;
    assign div_end  = (div_lim >> 1) - 20'h00001;
    always_ff @(posedge clk_sys) begin
        if (!nrst || state_q == ISC_IDLE) begin
            div_q <= '0;
        end else if (ref_tick) begin
            div_q <= (div_q >= div_end) ? '0 : div_q + 20'h00001;
        end
    end
    assign ph_tick = ref_tick && (div_q >= div_end);

    // Sampled lines: data feeds receive capture, the clock sample is read by nothing; no arbitration uses them
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sda_sync_q <= 2'h3;
            scl_sync_q <= 2'h3;
        end else begin
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_sync_q <= {scl_sync_q[0], scl_in};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q   <= ISC_IDLE;
            ph_q      <= '0;
            bit_q     <= '0;
            sh_q      <= '0;
            recv_q    <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else if (!enabled && state_q != ISC_IDLE) begin
            // Leaving the mode aborts the segment and lets both lines go
            // Limitation: a slave may be left mid-byte; software should send a stop
            state_q   <= ISC_IDLE;
            ph_q      <= '0;
            bit_q     <= '0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            case (state_q)
                ISC_IDLE: begin
                    ph_q <= '0;
                    bit_q <= '0;
                    if (enabled && one_hot) begin
                        if (seg_start_req) begin
                            state_q <= ISC_START;
                        end else if (seg_stop_req) begin
                            state_q <= ISC_STOP;
                        end else begin
                            state_q <= ISC_BYTE;
                            recv_q  <= seg_recv_req;
                            // Receive releases data and drives ack bit last
                            sh_q <= seg_recv_req ? {8'hFF, ~recv_ack_select}
                                                 : {tx_data, 1'b1};
                        end
                    end
                end
                ISC_START: if (ph_tick) begin
                    // Release data, raise clock, then pull data low: also a repeated start
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sda_low_q <= 1'b0;
                        2'h1: scl_low_q <= 1'b0;
                        2'h2: sda_low_q <= 1'b1;
                        default: begin
                            scl_low_q <= 1'b1;
                            state_q   <= ISC_DONE;
                        end
                    endcase
                end
                ISC_BYTE: if (ph_tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sda_low_q <= ~sh_q[8];
                        2'h1: scl_low_q <= 1'b0;
                        2'h2: sh_q <= {sh_q[7:0], 1'b1};
                        default: begin
                            scl_low_q <= 1'b1;
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == `ISC_BIT_LAST) begin
                                state_q <= ISC_DONE;
                            end
                        end
                    endcase
                end
                ISC_STOP: if (ph_tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sda_low_q <= 1'b1;
                        2'h1: scl_low_q <= 1'b0;
                        2'h2: sda_low_q <= 1'b0;
                        default: state_q <= ISC_DONE;
                    endcase
                end
                ISC_DONE: begin
                    // Wait for software to drop the request before the next segment
                    if (!(seg_start_req || seg_stop_req || seg_send_req || seg_recv_req)) begin
                        state_q <= ISC_IDLE;
                    end
                end
                default: state_q <= ISC_IDLE;
            endcase
        end
    end

    // Capture kept apart so the received byte moves only on receive segments
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rx_data <= '0;
            rx_nack <= 1'b0;
        end else if (state_q == ISC_BYTE && ph_tick && ph_q == 2'h2) begin
            if (bit_q == `ISC_BIT_LAST) begin
                rx_nack <= sda_sync_q[1];
            end else if (recv_q) begin
                rx_data <= {rx_data[6:0], sda_sync_q[1]};
            end
        end
    end

    // Completion flag holds until software clears its request bit
    assign seg_done = (state_q == ISC_DONE);
    assign busy     = (state_q != ISC_IDLE) && (state_q != ISC_DONE);

    // Open-collector: output fixed low, enable pulls; no high drive ever
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_low_q;
    assign sda_oe  = sda_low_q;
endmodule : isc_master

/* File: bench/isc_slave_model.sv */
// Slave model on the shared two-wire bus
`timescale 1ns/100ps
module isc_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic       rd_mode,
    input  wire logic [7:0] rd_byte,
    output logic            pull,
    output logic [8:0]      sh
);
    int cnt = 0;
    initial sh = 9'h000;
    always @(negedge sda) if (scl) cnt = 8;
    always @(negedge scl) cnt = (cnt == 8) ? 0 : cnt + 1;
    always @(posedge scl) sh = {sh[7:0], sda};
    // Only pulls low; pull-ups set the released level
    assign pull = rd_mode ? (cnt < 8 && !rd_byte[7 - cnt]) : (cnt == 8 && ack_en);
endmodule : isc_slave_model

/* File: bench/isc_master_asserts.sv */
// Port assertions for the two-wire bus master
`timescale 1ns/100ps
`include "isc_regs.svh"
module isc_master_asserts (
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    input wire logic [`ISC_MODE_W-1:0] serial_ctrl_mode_field,
    input wire logic                   seg_start_req,
    input wire logic                   seg_stop_req,
    input wire logic                   seg_send_req,
    input wire logic                   seg_recv_req,
    input wire logic                   seg_done,
    input wire logic                   busy,
    input wire logic                   scl_in,
    input wire logic                   sda_in,
    input wire logic                   scl_out,
    input wire logic                   sda_out
);
    logic [3:0] rq;
    assign rq = {seg_start_req, seg_stop_req, seg_send_req, seg_recv_req};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence take_s(logic [3:0] k);
        !busy && !seg_done && serial_ctrl_mode_field == `ISC_MODE_I2C && rq == k ##1 busy;
    endsequence
    a_lines_low_only: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("line driven high");
    a_mode_gate: assert property (!busy && !seg_done && serial_ctrl_mode_field != 3'h3 |=> !busy)
        else $error("taken outside mode");
    a_onehot_take: assert property (!busy && !seg_done && $countones(rq) != 1 |=> !busy)
        else $error("non one-hot taken");
    a_done_holds: assert property (seg_done && rq != 4'h0 |=> seg_done)
        else $error("done dropped early");
    a_done_release: assert property (seg_done && rq == 4'h0 |=> !seg_done && !busy)
        else $error("done not released");
    a_start_cond: assert property (take_s(4'h8) |-> ##[1:1000] (scl_in && $fell(sda_in)))
        else $error("no start condition");
    a_stop_cond: assert property (take_s(4'h4) |-> ##[1:1000] (scl_in && $rose(sda_in)))
        else $error("no stop condition");
    a_done_idle: assert property (seg_done |-> !busy)
        else $error("done while busy");
endmodule : isc_master_asserts

/* File: bench/testbench.sv */
// Bench for the two-wire bus master with a slave model
`timescale 1ns/100ps
`include "isc_regs.svh"
module testbench;
    logic clk_sys = 0, nrst = 0, recv_ack_select = 0, ack_en = 1, rd_mode = 0, done_q = 0;
    logic seg_start_req = 0, seg_stop_req = 0, seg_send_req = 0, seg_recv_req = 0;
    logic [`ISC_MODE_W-1:0] serial_ctrl_mode_field = 3'h2;
    logic [3:0] rate_exponent = 4'h3, rate_linear_column = 4'hE;
    logic [7:0] tx_data = 8'h00, rd_byte = 8'h00, lfsr = 8'h4A, rx_data;
    logic [8:0] sh;
    logic [10:0] ev, exp_q[$];
    logic rx_nack, seg_done, busy, scl_out, scl_oe, sda_out, sda_oe, pull;
    int mismatches = 0, check_count = 0;
    time t0, t1;
    wire scl_in = !scl_oe;
    wire sda_in = !(sda_oe || pull);
    isc_master uut (.*);
    isc_slave_model slave (.scl(scl_in), .sda(sda_in), .ack_en, .rd_mode, .rd_byte, .pull, .sh);
    function automatic logic [7:0] lfsr_next(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    task automatic chk(string n, logic [10:0] e, logic [10:0] s);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic seg(logic [3:0] k, logic [7:0] d, logic a, logic [10:0] e);
        int n;
        @(negedge clk_sys);
        {seg_start_req, seg_stop_req, seg_send_req, seg_recv_req} = k;
        tx_data = d;
        recv_ack_select = a;
        exp_q.push_back(e);
        for (n = 0; n < 6000 && seg_done !== 1'b1; n++) @(negedge clk_sys);
        chk("seg_done", 11'h1, {10'h0, seg_done});
        {seg_start_req, seg_stop_req, seg_send_req, seg_recv_req} = 4'h0;
        @(negedge clk_sys);
        rd_mode = 1'b0;
        chk("done_clear", 11'h0, {10'h0, seg_done});
    endtask : seg
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge scl_in) begin
        t0 = t1;
        t1 = $time;
    end
    // Results are judged at the falling edge, clear of the launching edge
    always @(negedge clk_sys) begin
        if (seg_done === 1'b1 && done_q !== 1'b1 && exp_q.size() > 0) begin
            ev = exp_q.pop_front();
            if (ev[10]) chk("byte", ev, {ev[10:9], rx_nack, ev[9] ? rx_data : sh[8:1]});
        end
        done_q = seg_done;
    end
    initial begin
        int i, r;
        logic [7:0] b;
        logic [10:0] p;
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        for (i = 0; i < 2; i++) begin
            serial_ctrl_mode_field = i ? `ISC_MODE_I2C : 3'h2;
            {seg_start_req, seg_stop_req} = i ? 2'h3 : 2'h2;
            repeat (20) @(negedge clk_sys);
            chk("refused", 11'h0, {9'h0, busy, sda_oe});
        end
        {seg_start_req, seg_stop_req} = 2'h0;
        for (r = 0; r < 3; r++) begin
            rate_linear_column = r == 2 ? 4'hF : 4'hE;
            rate_exponent = r == 0 ? 4'h3 : 4'h1;
            lfsr = lfsr_next(lfsr);
            ack_en = r != 1;
            b = r == 2 ? {5'h1E, lfsr[1:0], ack_en} : {lfsr[7:1], ack_en};
            seg(4'h8, 8'h00, 1'b0, 11'h0);
            seg(4'h2, b, 1'b0, {2'b10, !ack_en, b});
            p = 11'((((rate_linear_column + 1) << rate_exponent) / 2) * 2);
            chk("scl_period", p, 11'((t1 - t0) / 160));
            if (r == 2) seg(4'h2, lfsr, 1'b0, {3'h4, lfsr});
            if (ack_en) begin
                rd_mode = 1'b1;
                rd_byte = lfsr_next(lfsr);
                seg(4'h1, 8'h00, r == 2, {2'b11, r != 2, rd_byte});
            end else seg(4'h8, 8'h00, 1'b0, 11'h0);
            seg(4'h4, 8'h00, 1'b0, 11'h0);
        end
        test_done();
    end
    // Over three times the expected run of roughly 590 us
    initial begin
        #2000000;
        mismatches++;
        test_done();
    end
endmodule : testbench
bind isc_master isc_master_asserts chk_i (.*);
